/* File: logic/cmpd_pkg.sv */
// What this block does
// - The result is one when the positive analog input exceeds the negative one, else zero.
// - The comparator and its event logic work only while the enable bit is set.
// - For the plain conditions, the flag is set whenever the sampled result meets the selected condition.
// - The flag stays set until software clears it and is both polled and the irq request.
// - Comparator and event detection are off during idle and power-down.
// - The result is sampled once per machine cycle, at the fourth state slot.
// - Three of the selectable conditions are debounced variants.
// - Debounced conditions time the re-sample with timer 1 overflows.
// - After a relevant transition the block waits for two overflows, then re-samples.
// - A matching re-sample sets the flag; a mismatch drops the event.
// - Timer 1 is never restarted, so the flag comes one to two periods after the edge.
// - Codes: 0 low, 1 rise, 2 toggle deb, 3 rise deb, 4 fall, 5 toggle, 6 fall deb, 7 high.
// - Clearing the enable forces the result low and blocks further events.
// - The comparator interrupt is gated by bit 6 of the interrupt enable register.
package cmpd_pkg;

   localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
   localparam logic [11:0] ADDR_STATE       = 12'h004;
   localparam logic [11:0] ADDR_INT_ENABLE  = 12'h008;

   localparam int FLAG_BIT   = 4;
   localparam int ENABLE_BIT = 3;
   localparam int SEL_LSB    = 0;
   localparam int SEL_MSB    = 2;
   localparam int IE_CMP_BIT = 6;
   localparam int ST_RESULT  = 0;
   localparam int ST_PENDING = 1;
   localparam int ST_OVF_LSB = 2;

   localparam logic [2:0] RESET_SELECT = 3'h0;
   localparam logic       RESET_ENABLE = 1'b0;
   localparam logic       RESET_IE     = 1'b0;
   localparam logic [1:0] OVF_NEEDED   = 2'h2;

   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_NS     = 10000;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      CMPD_LOW_LEVEL   = 3'h0,
      CMPD_RISE        = 3'h1,
      CMPD_TOGGLE_DEB  = 3'h2,
      CMPD_RISE_DEB    = 3'h3,
      CMPD_FALL        = 3'h4,
      CMPD_TOGGLE      = 3'h5,
      CMPD_FALL_DEB    = 3'h6,
      CMPD_HIGH_LEVEL  = 3'h7
   } cmpd_mode_t;

   typedef enum logic {
      CMPD_DEB_IDLE = 1'b0,
      CMPD_DEB_WAIT = 1'b1
   } cmpd_deb_t;

   typedef struct packed {
      logic [2:0] ff;
      logic       level;
   } cmpd_sync_state_t;

   typedef struct packed {
      logic       enable;
      cmpd_mode_t mode;
      logic       flag;
      logic       ie;
      logic       result;
      logic       prev;
      logic       prev_valid;
      cmpd_deb_t  deb;
      logic       want;
      logic [1:0] ovf_count;
      logic [31:0] rdata;
      logic       slverr;
   } cmpd_state_t;

endpackage : cmpd_pkg

/* File: logic/cmpd_sync.sv */
`timescale 1ns/10ps
module cmpd_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Asynchronous level in, filtered level out
   input  wire logic async_in,
   output logic      level
);

   cmpd_pkg::cmpd_sync_state_t st;
   cmpd_pkg::cmpd_sync_state_t next_st;

   // The level only moves once the second and third stages agree.
   always_comb begin
      next_st = st;
      next_st.ff = {st.ff[1:0], async_in};
      if (st.ff[1] == st.ff[2]) begin
         next_st.level = st.ff[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;

endmodule : cmpd_sync

/* File: logic/cmpd_top.sv */
`timescale 1ns/10ps
module cmpd_top (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Comparator pin: high while the positive input exceeds the negative input
   input  wire logic        comparator_raw,
   // Core timing and power state
   input  wire logic        fourth_state_slot,
   input  wire logic        timer1_overflow,
   input  wire logic        idle_mode,
   input  wire logic        power_down,
   // Results
   output logic             comparator_result,
   output logic             comparator_irq
);

   cmpd_pkg::cmpd_state_t st;
   cmpd_pkg::cmpd_state_t next_st;

   logic raw_level;
   logic active;
   logic cur;
   logic rise;
   logic fall;
   logic hit_plain;
   logic hit_deb;
   logic confirm_due;
   logic set_flag;
   logic setup;
   logic access;
   logic rd_ctrl_done;

   // The pin is a comparator output from the analog domain.
   cmpd_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (comparator_raw),
      .level    (raw_level)
   );

   function automatic logic is_debounced(input cmpd_pkg::cmpd_mode_t m);
      return (m == cmpd_pkg::CMPD_TOGGLE_DEB) || (m == cmpd_pkg::CMPD_RISE_DEB) ||
             (m == cmpd_pkg::CMPD_FALL_DEB);
   endfunction : is_debounced

   // Condition match for one sample; debounced codes use their plain edge form.
   function automatic logic cond_hit(input cmpd_pkg::cmpd_mode_t m, input logic c,
                                     input logic r, input logic f);
      logic h;
      h = 1'b0;
      case (m)
         cmpd_pkg::CMPD_LOW_LEVEL:  h = !c;
         cmpd_pkg::CMPD_HIGH_LEVEL: h = c;
         cmpd_pkg::CMPD_RISE,
         cmpd_pkg::CMPD_RISE_DEB:   h = r;
         cmpd_pkg::CMPD_FALL,
         cmpd_pkg::CMPD_FALL_DEB:   h = f;
         cmpd_pkg::CMPD_TOGGLE,
         cmpd_pkg::CMPD_TOGGLE_DEB: h = r | f;
         default:                   h = 1'b0;
      endcase
      return h;
   endfunction : cond_hit

   always_comb begin
      active = st.enable && !idle_mode && !power_down;
      cur    = st.result;
      rise   = st.prev_valid && !st.prev && cur;
      fall   = st.prev_valid && st.prev && !cur;
      hit_plain = fourth_state_slot && active && !is_debounced(st.mode) &&
                  cond_hit(st.mode, cur, rise, fall);
      hit_deb   = fourth_state_slot && active && is_debounced(st.mode) &&
                  (st.deb == cmpd_pkg::CMPD_DEB_IDLE) && cond_hit(st.mode, cur, rise, fall);
      confirm_due = fourth_state_slot && active && is_debounced(st.mode) &&
                    (st.deb == cmpd_pkg::CMPD_DEB_WAIT) &&
                    (st.ovf_count == cmpd_pkg::OVF_NEEDED);
      set_flag = hit_plain || (confirm_due && (cur == st.want));
      setup  = psel && !penable;
      access = psel && penable;
      // A read clears the flag only if it returned it, so a set during setup is kept.
      rd_ctrl_done = access && !pwrite && (paddr == cmpd_pkg::ADDR_CTRL_STATUS) &&
                     st.rdata[cmpd_pkg::FLAG_BIT];
   end

   always_comb begin
      next_st = st;

      // Result is forced low whenever the comparator is off.
      next_st.result = raw_level && active;

      if (fourth_state_slot && active) begin
         next_st.prev       = cur;
         next_st.prev_valid = 1'b1;
      end
      if (!active) begin
         next_st.prev_valid = 1'b0;
      end

      // Debounce: overflows are only counted, timer 1 itself runs untouched.
      case (st.deb)
         cmpd_pkg::CMPD_DEB_IDLE: begin
            next_st.ovf_count = 2'h0;
            if (hit_deb) begin
               next_st.deb    = cmpd_pkg::CMPD_DEB_WAIT;
               next_st.want   = cur;
            end
         end
         cmpd_pkg::CMPD_DEB_WAIT: begin
            if (timer1_overflow && (st.ovf_count != cmpd_pkg::OVF_NEEDED)) begin
               next_st.ovf_count = st.ovf_count + 2'h1;
            end
            if (confirm_due) begin
               next_st.deb = cmpd_pkg::CMPD_DEB_IDLE;
            end
         end
         default: next_st.deb = cmpd_pkg::CMPD_DEB_IDLE;
      endcase
      if (!active || !is_debounced(st.mode)) begin
         next_st.deb       = cmpd_pkg::CMPD_DEB_IDLE;
         next_st.ovf_count = 2'h0;
      end

      // Register writes take effect at the completing edge.
      if (access && pwrite) begin
         if (paddr == cmpd_pkg::ADDR_CTRL_STATUS) begin
            next_st.enable = pwdata[cmpd_pkg::ENABLE_BIT];
            next_st.mode   = cmpd_pkg::cmpd_mode_t'(pwdata[cmpd_pkg::SEL_MSB:cmpd_pkg::SEL_LSB]);
         end else if (paddr == cmpd_pkg::ADDR_INT_ENABLE) begin
            next_st.ie = pwdata[cmpd_pkg::IE_CMP_BIT];
         end
      end

      // Reading the control register clears the flag; a new event wins.
      if (set_flag) begin
         next_st.flag = 1'b1;
      end else if (rd_ctrl_done) begin
         next_st.flag = 1'b0;
      end

      // Read data and error are prepared in the setup cycle.
      if (setup) begin
         next_st.rdata  = 32'h0000_0000;
         next_st.slverr = 1'b0;
         if (paddr == cmpd_pkg::ADDR_CTRL_STATUS) begin
            next_st.rdata[cmpd_pkg::FLAG_BIT]   = st.flag;
            next_st.rdata[cmpd_pkg::ENABLE_BIT] = st.enable;
            next_st.rdata[cmpd_pkg::SEL_MSB:cmpd_pkg::SEL_LSB] = st.mode;
         end else if (paddr == cmpd_pkg::ADDR_STATE) begin
            next_st.rdata[cmpd_pkg::ST_RESULT]  = st.result;
            next_st.rdata[cmpd_pkg::ST_PENDING] = (st.deb == cmpd_pkg::CMPD_DEB_WAIT);
            next_st.rdata[cmpd_pkg::ST_OVF_LSB+1:cmpd_pkg::ST_OVF_LSB] = st.ovf_count;
         end else if (paddr == cmpd_pkg::ADDR_INT_ENABLE) begin
            next_st.rdata[cmpd_pkg::IE_CMP_BIT] = st.ie;
         end else begin
            next_st.slverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st            <= '0;
         st.enable     <= cmpd_pkg::RESET_ENABLE;
         st.mode       <= cmpd_pkg::cmpd_mode_t'(cmpd_pkg::RESET_SELECT);
         st.ie         <= cmpd_pkg::RESET_IE;
         st.deb        <= cmpd_pkg::CMPD_DEB_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign pready            = psel && penable;
   assign prdata            = (psel && penable) ? st.rdata : 32'h0000_0000;
   assign pslverr           = psel && penable && st.slverr;
   assign comparator_result = st.result;
   assign comparator_irq    = st.flag && st.ie;

   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flag_sticky_hold: assert property (
      st.flag && !rd_ctrl_done |=> st.flag)
      else $error("event flag dropped without a clearing read");

   a_flag_needs_enable: assert property (
      $rose(st.flag) |-> $past(st.enable))
      else $error("event flag set while comparator disabled");

   a_lowpower_blocks: assert property (
      (idle_mode || power_down) && !st.flag |=> !st.flag)
      else $error("event flag set during idle or power-down");

   a_result_forced_low: assert property (
      !st.enable |=> !comparator_result)
      else $error("result not forced low while disabled");

   a_flag_on_slot: assert property (
      $rose(st.flag) |-> $past(fourth_state_slot))
      else $error("event flag set outside the fourth state slot");

   a_level_sets_flag: assert property (
      fourth_state_slot && active && (st.mode == cmpd_pkg::CMPD_HIGH_LEVEL) && cur
      |=> st.flag)
      else $error("high level did not set the flag");

   a_deb_two_overflows: assert property (
      $rose(st.flag) && $past(is_debounced(st.mode)) |-> $past(st.ovf_count) == 2'h2)
      else $error("debounced event confirmed before two overflows");

   a_deb_mismatch_drops: assert property (
      confirm_due && (cur != st.want) && !st.flag |=> !st.flag)
      else $error("mismatching re-sample set the flag");

   a_rise_sets_flag: assert property (
      fourth_state_slot && active && (st.mode == cmpd_pkg::CMPD_RISE) && rise |=> st.flag)
      else $error("rising edge did not set the flag");

   a_irq_follows_gate: assert property (
      st.flag && !st.ie |-> !comparator_irq)
      else $error("interrupt raised with its enable clear");

   c_debounced_event: cover property (
      confirm_due && (cur == st.want) ##1 st.flag);
   c_debounced_drop: cover property (confirm_due && (cur != st.want));
   c_level_event: cover property ($rose(st.flag) && (st.mode == cmpd_pkg::CMPD_LOW_LEVEL));
   c_read_clear: cover property (st.flag && rd_ctrl_done ##1 !st.flag);

endmodule : cmpd_top

/* File: verif/cmpd_far_side.sv */
`timescale 1ns/10ps
module cmpd_far_side #(
   parameter int TPER = 50
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Analog levels on the two comparator inputs
   input  wire logic [7:0] pos_level,
   input  wire logic [7:0] neg_level,
   // Comparator pin and core timing
   output logic            comparator_raw,
   output logic            fourth_state_slot,
   output logic            timer1_overflow
);
   int unsigned slot_cnt;
   int unsigned tmr_cnt;

   assign comparator_raw = (pos_level > neg_level);

   // The timer runs free and nobody restarts it, so debounce delays vary.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_cnt          <= 0;
         tmr_cnt           <= 0;
         fourth_state_slot <= 1'b0;
         timer1_overflow   <= 1'b0;
      end else begin
         slot_cnt          <= (slot_cnt + 1) % 4;
         fourth_state_slot <= (slot_cnt == 3);
         tmr_cnt           <= (tmr_cnt + 1) % TPER;
         timer1_overflow   <= (tmr_cnt == TPER - 1);
      end
   end
endmodule : cmpd_far_side

/* File: verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        comparator_raw;
   logic        fourth_state_slot;
   logic        timer1_overflow;
   logic        idle_mode = 1'b0;
   logic        power_down = 1'b0;
   logic        comparator_result;
   logic        comparator_irq;
   logic [7:0]  pos_level = 8'h00;
   logic [7:0]  neg_level = 8'h10;
   logic [31:0] q;
   logic        e;
   int          num_errors = 0;
   int          compares = 0;
   int          cycles = 0;

   always #5 pclk = ~pclk;

   cmpd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .comparator_raw(comparator_raw),
      .fourth_state_slot(fourth_state_slot), .timer1_overflow(timer1_overflow),
      .idle_mode(idle_mode), .power_down(power_down),
      .comparator_result(comparator_result), .comparator_irq(comparator_irq));

   cmpd_far_side #(.TPER(50)) u_far (.pclk(pclk), .presetn(presetn), .pos_level(pos_level),
      .neg_level(neg_level), .comparator_raw(comparator_raw),
      .fourth_state_slot(fourth_state_slot), .timer1_overflow(timer1_overflow));

   task automatic finish_test;
      $display("num_errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // Entered just after a rising edge; returns one idle cycle after release.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Random analog levels that put the comparator output at hi.
   task automatic set_in(input bit hi);
      logic [7:0] p;
      logic [7:0] n;
      do begin
         p = 8'($urandom);
         n = 8'($urandom);
      end while ((p > n) != hi);
      pos_level <= p;
      neg_level <= n;
   endtask : set_in

   function automatic logic exp_flag(input logic [2:0] m, input bit rising);
      return rising ? (m != 3'h4 && m != 3'h6) : (m != 3'h1 && m != 3'h3);
   endfunction : exp_flag

   initial begin
      void'($urandom(61375));
      cyc(6);
      presetn <= 1'b1;
      cyc(1);
      apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, cmpd_pkg::ADDR_INT_ENABLE, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, cmpd_pkg::ADDR_CTRL_STATUS, 32'h8);
      cyc(cmpd_pkg::SETTLE_CYCLES);
      apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
      apb(1'b1, cmpd_pkg::ADDR_INT_ENABLE, 32'h40);
      apb(1'b0, cmpd_pkg::ADDR_INT_ENABLE, 32'h0);
      chk(q, 32'h40);
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, cmpd_pkg::ADDR_CTRL_STATUS, {28'h0, 1'b1, 3'(m)});
         for (int r = 1; r >= 0; r--) begin
            set_in(!r);
            cyc(40);
            apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
            set_in(r);
            cyc(300);
            chk({31'h0, comparator_result}, 32'(r));
            chk({31'h0, comparator_irq}, 32'(exp_flag(3'(m), r)));
            apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
            chk(q, {27'h0, exp_flag(3'(m), r), 1'b1, 3'(m)});
         end
      end
      apb(1'b1, cmpd_pkg::ADDR_CTRL_STATUS, 32'h5);
      set_in(1);
      cyc(40);
      chk({31'h0, comparator_result}, 32'h0);
      apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
      set_in(0);
      cyc(20);
      set_in(1);
      cyc(300);
      apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk(q, 32'h5);
      apb(1'b1, cmpd_pkg::ADDR_CTRL_STATUS, 32'hD);
      for (int k = 0; k < 2; k++) begin
         idle_mode  <= (k == 0);
         power_down <= (k == 1);
         cyc(20);
         apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
         set_in(k);
         cyc(300);
         chk({31'h0, comparator_result}, 32'h0);
         apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
         chk(q, 32'hD);
      end
      idle_mode  <= 1'b0;
      power_down <= 1'b0;
      apb(1'b1, cmpd_pkg::ADDR_INT_ENABLE, 32'h0);
      apb(1'b1, cmpd_pkg::ADDR_CTRL_STATUS, 32'hB);
      set_in(0);
      cyc(40);
      apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
      set_in(1);
      cyc(12);
      apb(1'b0, cmpd_pkg::ADDR_STATE, 32'h0);
      chk(q & 32'h3, 32'h3);
      set_in(0);
      cyc(300);
      apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk(q, 32'hB);
      apb(1'b1, cmpd_pkg::ADDR_CTRL_STATUS, 32'hF);
      set_in(1);
      cyc(40);
      chk({31'h0, comparator_irq}, 32'h0);
      apb(1'b0, cmpd_pkg::ADDR_CTRL_STATUS, 32'h0);
      chk(q, 32'h1F);
      apb(1'b0, cmpd_pkg::ADDR_STATE, 32'h0);
      chk(q, 32'h1);
      finish_test();
   end
endmodule : testbench
